/* File: hw/power_mode_regs.vh */
// Purpose: shared constants of the power mode controller
// Assumes: included by bare name from the design files
// Notes:   definitions only, no logic
`ifndef POWER_MODE_REGS_VH
`define POWER_MODE_REGS_VH

// global mode codes, highest to lowest consumption
`define MODE_ACTIVE     2'h0
`define MODE_ALT        2'h1
`define MODE_SLEEP      2'h2
`define MODE_HIBER      2'h3

// wakeup source vector positions
`define WK_COMP         0
`define WK_PORT         1
`define WK_I2C          2
`define WK_RTC          3
`define WK_CTW          4
`define WK_LVD          5
`define WK_W            6

// reset source vector positions
`define RS_EXTERNAL_RESET_PIN         0
`define RS_LVD          1
`define RS_WDOG         2
`define RS_PREC         3
`define RS_W            4

// template bit that powers the cpu
`define CPU_TMPL_BIT    0

// reset values
`define MODE_RST        2'h0
`define CPU_EN_RST      1'b1
`define FLAG_RST        1'b0

// timing in its own units and derived cycle counts
`define CLK_PERIOD_NS   25
`define SLEEP_RESUME_US 15
`define HIBER_RESUME_US 100
`define SYNC_LAT        4
`define SLEEP_RESUME_CYC ((`SLEEP_RESUME_US * 1000) / `CLK_PERIOD_NS)
`define HIBER_RESUME_CYC ((`HIBER_RESUME_US * 1000) / `CLK_PERIOD_NS)
`define RESUME_CNT_W    12

// central timewheel
`define TW_WIDTH        13
`define TW_TICK_HZ      1000

`endif

/* File: hw/central_timewheel.v */
// Purpose: free running counter stepped by low speed oscillator ticks
// Assumes: tick is a one-cycle pulse already in the clk domain
// Notes:   wrap pulses once per full count cycle
`timescale 1ns/10ps
`default_nettype none
`include "power_mode_regs.vh"

module central_timewheel #(
    parameter WIDTH = `TW_WIDTH
) (
    input  wire             clk,
    input  wire             resetn,
    input  wire             tick,
    input  wire             run,
    input  wire             clear,
    output reg  [WIDTH-1:0] count_r,
    output reg              wrap_r
);

    wire [WIDTH-1:0] count_nxt;
    wire             at_top;

    assign at_top    = &count_r;
    assign count_nxt = count_r + {{(WIDTH-1){1'b0}}, 1'b1};

    // counter holds while stopped; firmware clear wins over a tick
    always @(posedge clk or negedge resetn) begin
        if (!resetn) begin
            count_r <= {WIDTH{1'b0}};
            wrap_r  <= 1'b0;
        end else begin
            wrap_r <= 1'b0;
            if (clear) begin
                count_r <= {WIDTH{1'b0}};
            end else if (run && tick) begin
                count_r <= count_nxt;
                wrap_r  <= at_top;
            end
        end
    end

endmodule
`default_nettype wire

/* File: hw/power_mode_controller.v */
// Purpose: sequences the chip through its global power modes
// Assumes: single clk; wake, reset and oscillator pins are asynchronous
// Notes:   templates and requests come from firmware logic on clk
//
// Operation
// - four modes ranked active, alternate, sleep, hibernate
// - active modes power each subsystem by template bit
// - disabled subsystem loses clock and bias
// - template changes apply while staying active
// - active entered on wake, reset or write
// - low modes entered only by firmware write
// - cpu may disable itself until next wake
// - wake forces active mode and cpu on
// - mode after boot is active
// - sleep stops all but low speed clocks
// - sleep wakes from six listed sources only
// - sleep resume finishes under 15 us
// - sleep accepts pin, voltage and watchdog resets
// - hibernate stops clocks, keeps state, one regulator
// - hibernate exits by port interrupt, pin reset
// - hibernate resume finishes under 100 us
// - hibernate holds outputs and pin interrupt setup
// - timewheel 13-bit at 1 kHz, off in hibernate
// - pin reset also wakes hibernate; pin, voltage and watchdog resets wake sleep
`timescale 1ns/10ps
`default_nettype none
`include "power_mode_regs.vh"

module power_mode_controller #(
    parameter NSUB = 8
) (
    input  wire                 clk,
    input  wire                 resetn,
    input  wire                 mode_req_valid,
    input  wire [1:0]           mode_req_code,
    input  wire                 bus_busy,
    input  wire                 cpu_off_req,
    input  wire [NSUB-1:0]      active_template,
    input  wire [NSUB-1:0]      alt_template,
    input  wire [`WK_W-1:0]     wake_enable,
    input  wire                 irq_any,
    input  wire                 timewheel_clear,
    input  wire                 xtal_select,
    input  wire                 wake_comparator,
    input  wire                 wake_port_int,
    input  wire                 wake_i2c,
    input  wire                 wake_rtc,
    input  wire                 wake_lvd,
    input  wire                 low_speed_internal_osc,
    input  wire                 external_reset_pin,
    input  wire                 low_voltage_detect,
    input  wire                 watchdog_reset,
    input  wire                 precision_reset,
    output reg  [1:0]           mode_r,
    output reg                  resuming_r,
    output reg  [NSUB-1:0]      clk_gate_en_r,
    output reg  [NSUB-1:0]      bias_en_r,
    output reg                  cpu_en_r,
    output reg                  main_clk_en_r,
    output reg                  low_speed_osc_en_r,
    output reg                  watch_crystal_osc_en_r,
    output reg                  core_reg_en_r,
    output reg                  sleep_reg_en_r,
    output reg                  io_hold_r,
    output reg                  reset_req_r,
    output reg                  req_pending_r,
    output wire [`TW_WIDTH-1:0] timewheel_count_r
);

    localparam ST_ACTIVE = 3'h0;
    localparam ST_ALT    = 3'h1;
    localparam ST_SLEEP  = 3'h2;
    localparam ST_HIBER  = 3'h3;
    localparam ST_RESUME = 3'h4;
    localparam NASYNC    = 11;
    localparam CW        = `RESUME_CNT_W;
    localparam [CW-1:0] SLEEP_LOAD =
        `SLEEP_RESUME_CYC - `SYNC_LAT;
    localparam [CW-1:0] HIBER_LOAD =
        `HIBER_RESUME_CYC - `SYNC_LAT;

    reg  [NASYNC-1:0] sync1_r;
    reg  [NASYNC-1:0] sync2_r;
    reg               osc_last_r;
    reg  [2:0]        state_r;
    reg  [2:0]        state_nxt;
    reg  [1:0]        lp_mode_r;
    reg  [1:0]        lp_mode_nxt;
    reg  [1:0]        pend_code_r;
    reg  [CW-1:0]     resume_cnt_r;
    reg  [CW-1:0]     resume_cnt_nxt;
    reg               cpu_off_r;
    reg               cpu_force_r;
    reg               wake_now;
    reg               rst_now;
    reg               apply_now;
    reg               enter_low;
    reg  [1:0]        mode_nxt;
    reg  [NSUB-1:0]   gate_nxt;
    reg               cpu_nxt;
    wire [NASYNC-1:0] async_in;
    wire [`WK_W-1:0]  wake_vec;
    wire [`RS_W-1:0]  rst_vec;
    wire              osc_tick;
    wire              tw_wrap;
    wire              tw_run;
    wire [1:0]        eff_mode;

    // every pin level is brought into clk before anything looks at it
    assign async_in = {precision_reset, watchdog_reset, low_voltage_detect,
                       external_reset_pin, low_speed_internal_osc,
                       wake_lvd, wake_rtc, wake_i2c, wake_port_int,
                       wake_comparator, 1'b0};

    genvar gi;
    generate
        for (gi = 0; gi < NASYNC; gi = gi + 1) begin : g_sync
            // two stages per pin; only stage two is read
            always @(posedge clk or negedge resetn) begin
                if (!resetn) begin
                    sync1_r[gi] <= 1'b0;
                    sync2_r[gi] <= 1'b0;
                end else begin
                    sync1_r[gi] <= async_in[gi];
                    sync2_r[gi] <= sync1_r[gi];
                end
            end
        end
    endgenerate

    // rising edge of the synchronised low speed oscillator
    always @(posedge clk or negedge resetn) begin
        if (!resetn) begin
            osc_last_r <= 1'b0;
        end else begin
            osc_last_r <= sync2_r[6];
        end
    end

    assign osc_tick = sync2_r[6] & ~osc_last_r;
    assign rst_vec  = {sync2_r[10], sync2_r[9], sync2_r[8], sync2_r[7]};

    // timewheel wrap is an internal wakeup source
    assign wake_vec = {sync2_r[5], tw_wrap, sync2_r[4], sync2_r[3],
                       sync2_r[2], sync2_r[1]};

    // stopped while in hibernate or climbing out of it
    assign tw_run = (state_r != ST_HIBER) &&
                    !((state_r == ST_RESUME) &&
                      (lp_mode_r == `MODE_HIBER));

    central_timewheel #(
        .WIDTH (`TW_WIDTH)
    ) u_timewheel (
        .clk     (clk),
        .resetn  (resetn),
        .tick    (osc_tick),
        .run     (tw_run),
        .clear   (timewheel_clear),
        .count_r (timewheel_count_r),
        .wrap_r  (tw_wrap)
    );

    // mode whose wake and reset rules apply right now
    assign eff_mode = (state_r == ST_RESUME) ? lp_mode_r : mode_r;

    // which enabled wake sources may end the given mode
    function wake_ok;
        input [1:0]       m;
        input [`WK_W-1:0] w;
        input             irq;
        begin
            case (m)
                `MODE_SLEEP: wake_ok = |w;
                `MODE_HIBER: wake_ok = w[`WK_PORT];
                default:     wake_ok = irq | (|w);
            endcase
        end
    endfunction

    // which reset sources the given mode honours
    function reset_ok;
        input [1:0]       m;
        input [`RS_W-1:0] r;
        begin
            case (m)
                `MODE_SLEEP: reset_ok = r[`RS_EXTERNAL_RESET_PIN] | r[`RS_LVD] |
                                        r[`RS_WDOG];
                `MODE_HIBER: reset_ok = r[`RS_EXTERNAL_RESET_PIN];
                default:     reset_ok = |r;
            endcase
        end
    endfunction

    // mode sequencing
    always @* begin
        state_nxt      = state_r;
        lp_mode_nxt    = lp_mode_r;
        resume_cnt_nxt = resume_cnt_r;
        apply_now      = 1'b0;
        enter_low      = 1'b0;
        wake_now = wake_ok(eff_mode, wake_vec & wake_enable,
                           irq_any);
        rst_now  = reset_ok(eff_mode, rst_vec);
        case (state_r)
            ST_ACTIVE, ST_ALT: begin
                if (rst_now || wake_now) begin
                    state_nxt = ST_ACTIVE;
                end else if (req_pending_r && !bus_busy) begin
                    apply_now = 1'b1;
                    case (pend_code_r)
                        `MODE_ALT:   state_nxt = ST_ALT;
                        `MODE_SLEEP: state_nxt = ST_SLEEP;
                        `MODE_HIBER: state_nxt = ST_HIBER;
                        default:     state_nxt = ST_ACTIVE;
                    endcase
                    enter_low   = pend_code_r[1];
                    lp_mode_nxt = pend_code_r;
                end
            end
            ST_SLEEP: begin
                if (rst_now || wake_now) begin
                    state_nxt      = ST_RESUME;
                    resume_cnt_nxt = SLEEP_LOAD;
                end
            end
            ST_HIBER: begin
                if (rst_now || wake_now) begin
                    state_nxt      = ST_RESUME;
                    resume_cnt_nxt = HIBER_LOAD;
                end
            end
            ST_RESUME: begin
                // regulators settle before active clocks return
                if (resume_cnt_r == {CW{1'b0}}) begin
                    state_nxt = ST_ACTIVE;
                end else begin
                    resume_cnt_nxt = resume_cnt_r - {{(CW-1){1'b0}}, 1'b1};
                end
            end
            default: begin
                state_nxt = ST_ACTIVE;
            end
        endcase
    end

    // outputs derived from the next state
    always @* begin
        mode_nxt = `MODE_ACTIVE;
        gate_nxt = {NSUB{1'b0}};
        cpu_nxt  = 1'b0;
        case (state_nxt)
            ST_ACTIVE: begin
                mode_nxt = `MODE_ACTIVE;
                gate_nxt = active_template;
                cpu_nxt  = (active_template[`CPU_TMPL_BIT] &
                            ~cpu_off_r) | cpu_force_r;
            end
            ST_ALT: begin
                mode_nxt = `MODE_ALT;
                gate_nxt = alt_template;
                cpu_nxt  = (alt_template[`CPU_TMPL_BIT] &
                            ~cpu_off_r) | cpu_force_r;
            end
            ST_SLEEP: begin
                mode_nxt = `MODE_SLEEP;
            end
            ST_HIBER: begin
                mode_nxt = `MODE_HIBER;
            end
            ST_RESUME: begin
                mode_nxt = lp_mode_r;
            end
            default: begin
                mode_nxt = `MODE_ACTIVE;
            end
        endcase
        // a wake turns the cpu on whatever its template says
        if (wake_now || rst_now) begin
            if (state_nxt == ST_ACTIVE) begin
                cpu_nxt = 1'b1;
            end
        end
    end

    // state and bookkeeping registers
    always @(posedge clk or negedge resetn) begin
        if (!resetn) begin
            state_r      <= ST_ACTIVE;
            lp_mode_r    <= `MODE_RST;
            resume_cnt_r <= {CW{1'b0}};
            mode_r       <= `MODE_RST;
            resuming_r   <= `FLAG_RST;
        end else begin
            state_r      <= state_nxt;
            lp_mode_r    <= lp_mode_nxt;
            resume_cnt_r <= resume_cnt_nxt;
            mode_r       <= mode_nxt;
            resuming_r   <= (state_nxt == ST_RESUME);
        end
    end

    // firmware request waits for the bus; a new request beats the apply
    always @(posedge clk or negedge resetn) begin
        if (!resetn) begin
            req_pending_r <= `FLAG_RST;
            pend_code_r   <= `MODE_RST;
        end else begin
            if (mode_req_valid) begin
                req_pending_r <= 1'b1;
                pend_code_r   <= mode_req_code;
            end else if (apply_now) begin
                req_pending_r <= 1'b0;
            end else if ((wake_now || rst_now) && pend_code_r[1]) begin
                // a wake before entry cancels a low power request
                req_pending_r <= 1'b0;
            end
        end
    end

    // cpu self disable, undone by the next wake; the wake wins a tie
    always @(posedge clk or negedge resetn) begin
        if (!resetn) begin
            cpu_off_r   <= `FLAG_RST;
            cpu_force_r <= `FLAG_RST;
        end else begin
            if (wake_now || rst_now) begin
                cpu_off_r   <= 1'b0;
                cpu_force_r <= 1'b1;
            end else if (cpu_off_req) begin
                cpu_off_r   <= 1'b1;
                cpu_force_r <= 1'b0;
            end else if (enter_low || apply_now) begin
                cpu_force_r <= 1'b0;
            end
        end
    end

    // power, clock and hold controls, registered every cycle
    always @(posedge clk or negedge resetn) begin
        if (!resetn) begin
            clk_gate_en_r          <= {NSUB{1'b1}};
            bias_en_r              <= {NSUB{1'b1}};
            cpu_en_r               <= `CPU_EN_RST;
            main_clk_en_r          <= 1'b1;
            low_speed_osc_en_r     <= 1'b1;
            watch_crystal_osc_en_r <= 1'b0;
            core_reg_en_r          <= 1'b1;
            sleep_reg_en_r         <= 1'b0;
            io_hold_r              <= 1'b0;
            reset_req_r            <= 1'b0;
        end else begin
            clk_gate_en_r <= gate_nxt;
            bias_en_r     <= gate_nxt;
            cpu_en_r      <= cpu_nxt;
            main_clk_en_r <= (state_nxt == ST_ACTIVE) ||
                             (state_nxt == ST_ALT);
            // low speed clocks live on in every mode but hibernate and the climb out of it
            low_speed_osc_en_r <= (mode_nxt != `MODE_HIBER);
            watch_crystal_osc_en_r <= xtal_select &&
                                      (mode_nxt != `MODE_HIBER);
            core_reg_en_r  <= (state_nxt == ST_ACTIVE) ||
                              (state_nxt == ST_ALT) ||
                              (state_nxt == ST_RESUME);
            sleep_reg_en_r <= (state_nxt == ST_SLEEP);
            // pins keep their levels until the climb out is done
            io_hold_r <= (mode_nxt == `MODE_HIBER);
            reset_req_r <= rst_now;
        end
    end

endmodule
`default_nettype wire

/* File: bench/power_mode_props.sv */
// Purpose: port checks on the power mode controller
// Assumes: one clk domain, resetn async active low
// Notes:   bound to every controller instance
`timescale 1ns/10ps
`default_nettype none
`include "power_mode_regs.vh"

module power_mode_props #(
    parameter NSUB = 8
) (
    input wire logic                 clk,
    input wire logic                 resetn,
    input wire logic                 bus_busy,
    input wire logic [NSUB-1:0]      active_template,
    input wire logic                 timewheel_clear,
    input wire logic [`WK_W-1:0]     wake_enable,
    input wire logic                 wake_comparator,
    input wire logic                 wake_port_int,
    input wire logic                 wake_i2c,
    input wire logic                 wake_rtc,
    input wire logic                 wake_lvd,
    input wire logic                 external_reset_pin,
    input wire logic                 low_voltage_detect,
    input wire logic                 watchdog_reset,
    input wire logic [1:0]           mode_r,
    input wire logic                 resuming_r,
    input wire logic [NSUB-1:0]      clk_gate_en_r,
    input wire logic [NSUB-1:0]      bias_en_r,
    input wire logic                 cpu_en_r,
    input wire logic                 main_clk_en_r,
    input wire logic                 low_speed_osc_en_r,
    input wire logic                 core_reg_en_r,
    input wire logic                 sleep_reg_en_r,
    input wire logic                 io_hold_r,
    input wire logic [`TW_WIDTH-1:0] timewheel_count_r
);
    localparam int SLP_RES = 597;
    localparam int HIB_RES = 3997;
    logic [11:0]     res_cnt_r;
    logic [NSUB-1:0] tmpl_d_r;

    // resume length and last template
    always_ff @(posedge clk or negedge resetn) begin
        if (!resetn) begin
            res_cnt_r <= 12'h000;
            tmpl_d_r  <= '0;
        end else begin
            res_cnt_r <= resuming_r ? res_cnt_r + 12'h001 : 12'h000;
            tmpl_d_r  <= active_template;
        end
    end

    default clocking @(posedge clk); endclocking
    default disable iff (!resetn);

    // five quiet cycles outlast the sync flops
    sequence s_hib_quiet;
        (mode_r == `MODE_HIBER && !resuming_r && !wake_port_int &&
         !external_reset_pin) [*5];
    endsequence
    sequence s_slp_quiet;
        (mode_r == `MODE_SLEEP && !resuming_r && !wake_comparator &&
         !wake_port_int && !wake_i2c && !wake_rtc && !wake_lvd &&
         !external_reset_pin && !low_voltage_detect && !watchdog_reset &&
         !wake_enable[`WK_CTW]) [*5];
    endsequence
    sequence s_act;
        mode_r == `MODE_ACTIVE && !resuming_r;
    endsequence

    property p_sleep_off;
        mode_r == `MODE_SLEEP && !resuming_r |-> !main_clk_en_r &&
            clk_gate_en_r == '0 && sleep_reg_en_r && low_speed_osc_en_r &&
            !core_reg_en_r;
    endproperty
    a_sleep_off: assert property (p_sleep_off)
        else $error("sleep left a fast resource on");
    property p_hib_off;
        mode_r == `MODE_HIBER && !resuming_r |-> !low_speed_osc_en_r &&
            !main_clk_en_r && !core_reg_en_r && !sleep_reg_en_r &&
            io_hold_r && clk_gate_en_r == '0;
    endproperty
    a_hib_off: assert property (p_hib_off)
        else $error("hibernate outputs wrong");
    property p_act_tmpl;
        s_act ##1 s_act |-> clk_gate_en_r[NSUB-1:1] == tmpl_d_r[NSUB-1:1];
    endproperty
    a_act_tmpl: assert property (p_act_tmpl)
        else $error("gates do not follow active template");
    property p_bias;
        mode_r inside {`MODE_ACTIVE, `MODE_ALT} && !resuming_r |->
            bias_en_r[NSUB-1:1] == clk_gate_en_r[NSUB-1:1];
    endproperty
    a_bias: assert property (p_bias)
        else $error("bias and clock gate disagree");
    property p_slp_resume;
        $rose(resuming_r) && mode_r == `MODE_SLEEP |->
            ##[1:SLP_RES] (s_act and cpu_en_r);
    endproperty
    a_slp_resume: assert property (p_slp_resume)
        else $error("sleep resume too long");
    property p_hib_resume;
        resuming_r && mode_r == `MODE_HIBER |-> res_cnt_r < HIB_RES;
    endproperty
    a_hib_resume: assert property (p_hib_resume)
        else $error("hibernate resume too long");
    property p_hib_wake;
        s_hib_quiet |=> !resuming_r;
    endproperty
    a_hib_wake: assert property (p_hib_wake)
        else $error("hibernate left by a foreign source");
    property p_slp_wake;
        s_slp_quiet |=> !resuming_r;
    endproperty
    a_slp_wake: assert property (p_slp_wake)
        else $error("sleep left by a foreign source");
    property p_busy_hold;
        bus_busy && mode_r inside {`MODE_ACTIVE, `MODE_ALT} && !resuming_r
            |=> mode_r == $past(mode_r) || mode_r == `MODE_ACTIVE;
    endproperty
    a_busy_hold: assert property (p_busy_hold)
        else $error("mode changed during bus transfer");
    property p_tw_hold;
        (mode_r == `MODE_HIBER && !resuming_r && !timewheel_clear) ##1
            (mode_r == `MODE_HIBER && !resuming_r) |->
            $stable(timewheel_count_r);
    endproperty
    a_tw_hold: assert property (p_tw_hold)
        else $error("timewheel moved in hibernate");
endmodule

bind power_mode_controller power_mode_props #(.NSUB(NSUB)) u_props (.*);
`default_nettype wire

/* File: bench/wake_source_model.sv */
// Purpose: far side stand-in for wake, reset and oscillator sources
// Assumes: event pins idle low, as if pulled down
// Notes:   oscillator sped up to fit a wrap in one run
`timescale 1ns/10ps
`default_nettype none

module wake_source_model #(
    parameter OSC_HALF_NS = 75
) (
    input  wire logic       clk,
    output var  logic       osc,
    output var  logic [8:0] pins
);
    // free running oscillator, phase unrelated to clk
    initial begin
        osc  = 1'b0;
        pins = 9'h000;
        #11;
        forever #(OSC_HALF_NS) osc = ~osc;
    end

    // raise events for len cycles; single slow toggles only
    task automatic pulse(input logic [8:0] mask, input int len);
        @(posedge clk);
        pins <= pins | mask;
        repeat (len) @(posedge clk);
        pins <= 9'h000;
    endtask
endmodule
`default_nettype wire

/* File: bench/tb_top.sv */
// Purpose: directed tests of the power mode controller
// Assumes: wake_source_model drives event pins and oscillator
// Notes:   pin order comp,port,i2c,rtc,wlvd,external_reset_pin,lvd,wdog,prec
`timescale 1ns/10ps
`default_nettype none
`include "power_mode_regs.vh"
`define CHK(nm, e, g) begin n_tests++; if ((g) !== (e)) begin failures++; \
    $display("unexpected %s expected %0h seen %0h", nm, e, g); end end

module tb_top;
    logic clk, resetn, mode_req_valid, bus_busy, cpu_off_req, irq_any;
    logic timewheel_clear, xtal_select, osc, resuming_r, cpu_en_r;
    logic main_clk_en_r, low_speed_osc_en_r, watch_crystal_osc_en_r;
    logic core_reg_en_r, sleep_reg_en_r, io_hold_r, reset_req_r;
    logic        req_pending_r;
    logic [1:0]  mode_req_code, mode_r;
    logic [5:0]  wake_enable;
    logic [7:0]  active_template, alt_template, clk_gate_en_r, bias_en_r;
    logic [8:0]  ev;
    logic [12:0] timewheel_count_r, m;
    int          failures, n_tests, n;
    logic [1:0]  tgt [10] = '{2'h2, 2'h2, 2'h2, 2'h2, 2'h2, 2'h2, 2'h2,
                              2'h2, 2'h3, 2'h3};
    int          idx [10] = '{0, 2, 3, 4, 5, 6, 7, 1, 5, 1};

    wake_source_model src (.clk, .osc, .pins(ev));
    power_mode_controller #(.NSUB(8)) dut (
        .clk, .resetn, .mode_req_valid, .mode_req_code, .bus_busy,
        .cpu_off_req, .active_template, .alt_template, .wake_enable,
        .irq_any, .timewheel_clear, .xtal_select,
        .wake_comparator(ev[0]), .wake_port_int(ev[1]), .wake_i2c(ev[2]),
        .wake_rtc(ev[3]), .wake_lvd(ev[4]), .low_speed_internal_osc(osc),
        .external_reset_pin(ev[5]), .low_voltage_detect(ev[6]),
        .watchdog_reset(ev[7]), .precision_reset(ev[8]), .mode_r,
        .resuming_r, .clk_gate_en_r, .bias_en_r, .cpu_en_r, .main_clk_en_r,
        .low_speed_osc_en_r, .watch_crystal_osc_en_r, .core_reg_en_r,
        .sleep_reg_en_r, .io_hold_r, .reset_req_r, .req_pending_r,
        .timewheel_count_r);

    // 40 MHz clock
    always #12.5 clk = ~clk;

    // sample one step past the edge
    task automatic cyc(input int k);
        repeat (k) @(posedge clk);
        #1;
    endtask
    task automatic req(input logic [1:0] c);
        @(posedge clk);
        mode_req_valid <= 1'b1;
        mode_req_code  <= c;
        @(posedge clk);
        mode_req_valid <= 1'b0;
        cyc(3);
    endtask
    task automatic pulse(input int which);
        @(posedge clk);
        if (which == 0) irq_any <= 1'b1;
        else cpu_off_req <= 1'b1;
        @(posedge clk);
        irq_any     <= 1'b0;
        cpu_off_req <= 1'b0;
        cyc(3);
    endtask
    // bounded wait for settled active mode
    task automatic wait_act(input int lim, output int k);
        k = 0;
        while (!(mode_r === `MODE_ACTIVE && resuming_r === 1'b0) && k < lim)
        begin
            cyc(1);
            k++;
        end
    endtask
    task automatic final_report;
        $display("checks %0d mismatches %0d", n_tests, failures);
        if (failures == 0 && n_tests > 0)
            $display("Result: passed");
        else
            $display("Result: failed");
        $finish;
    endtask

    // watchdog past the expected 63k cycles
    initial begin
        #(90000 * 25);
        failures++;
        final_report;
    end

    initial begin
        clk = 0; resetn = 0; mode_req_valid = 0; mode_req_code = 2'h0;
        bus_busy = 0; cpu_off_req = 0; irq_any = 0; timewheel_clear = 0;
        active_template = 8'hFF; alt_template = 8'h3C; wake_enable = 6'h2F;
        xtal_select = 1; failures = 0; n_tests = 0;
        repeat (6) @(posedge clk);
        resetn <= 1'b1;
        cyc(1);
        `CHK("mode", `MODE_ACTIVE, mode_r)
        `CHK("cpu", 1'b1, cpu_en_r)
        `CHK("pend", 1'b0, req_pending_r)
        `CHK("gate", 8'hFF, clk_gate_en_r)
        @(posedge clk);
        active_template <= 8'hA5;
        cyc(2);
        `CHK("gate", 8'hA5, clk_gate_en_r)
        `CHK("bias", 8'hA5, bias_en_r)
        $display("test boot and template done");
        @(posedge clk);
        bus_busy <= 1'b1;
        req(2'h1);
        `CHK("mode", `MODE_ACTIVE, mode_r)
        `CHK("pend", 1'b1, req_pending_r)
        @(posedge clk);
        bus_busy <= 1'b0;
        cyc(3);
        `CHK("mode", `MODE_ALT, mode_r)
        `CHK("gate", 7'h1E, clk_gate_en_r[7:1])
        `CHK("cpu", 1'b0, cpu_en_r)
        pulse(0);
        `CHK("mode", `MODE_ACTIVE, mode_r)
        `CHK("cpu", 1'b1, cpu_en_r)
        pulse(1);
        `CHK("cpu", 1'b0, cpu_en_r)
        pulse(0);
        `CHK("cpu", 1'b1, cpu_en_r)
        $display("test alternate and cpu off done");
        req(2'h2);
        `CHK("mode", `MODE_SLEEP, mode_r)
        `CHK("mclk", 1'b0, main_clk_en_r)
        `CHK("gate", 8'h00, clk_gate_en_r)
        `CHK("xtal", 1'b1, watch_crystal_osc_en_r)
        src.pulse(9'h100, 4);
        pulse(0);
        cyc(5);
        `CHK("res", 1'b0, resuming_r)
        // each listed source wakes its mode within the resume limit
        for (int i = 0; i < 10; i++) begin
            if (mode_r !== tgt[i])
                req(tgt[i]);
            if (tgt[i] == 2'h3) begin
                `CHK("hold", 1'b1, io_hold_r)
                src.pulse(9'h1DD, 4);
                cyc(20);
                `CHK("res", 1'b0, resuming_r)
            end
            src.pulse(9'h001 << idx[i], 4);
            wait_act(tgt[i] == 2'h3 ? 4000 : 600, n);
            `CHK("wake", 1'b1, n + 3 <= (tgt[i] == 2'h3 ? 4000 : 600))
            `CHK("cpu", 1'b1, cpu_en_r)
        end
        $display("test wake sources done");
        m = timewheel_count_r;
        n = 0;
        while (timewheel_count_r === m && n < 20) begin
            cyc(1);
            n++;
        end
        m = timewheel_count_r;
        cyc(63);
        `CHK("tw", m + 13'h000A, timewheel_count_r)
        @(posedge clk);
        timewheel_clear <= 1'b1;
        wake_enable     <= 6'h3F;
        @(posedge clk);
        timewheel_clear <= 1'b0;
        cyc(2);
        `CHK("clr", 1'b1, timewheel_count_r <= 13'h0001)
        req(2'h2);
        wait_act(52000, n);
        `CHK("ctw", 1'b1, n < 52000)
        `CHK("wrap", 1'b1, timewheel_count_r < 13'h0100)
        $display("test timewheel done");
        final_report;
    end
endmodule
`default_nettype wire
